/* File: src/comp_mix_pkg.sv */
// constants shared by the component video mixer: register map, fields, resets, math
// assumes a 32-bit ahb-lite register bus and 8-bit video samples
package comp_mix_pkg;
  localparam int SAMPLE_W = 8;
  localparam int LEVEL_W  = 6;
  // register byte addresses
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_PICT = 32'h0000_0004;
  localparam logic [31:0] OFS_TINT = 32'h0000_0008;
  localparam logic [31:0] OFS_MIX  = 32'h0000_000c;
  localparam logic [31:0] OFS_STAT = 32'h0000_0010;
  // field positions
  localparam int CTRL_RGB_BIT   = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_CLAMP_BIT = 3;
  localparam int CTRL_CURVE_BIT = 4;
  localparam int CTRL_DLY_BIT   = 5;
  localparam int PICT_CON_LSB   = 0;
  localparam int PICT_BRI_LSB   = 8;
  localparam int PICT_SCR_LSB   = 16;
  localparam int PICT_SCB_LSB   = 24;
  localparam int MIX_GAIN_LSB   = 0;
  localparam int MIX_OFFS_LSB   = 8;
  localparam int STAT_K_LSB     = 0;
  localparam int STAT_LVL_LSB   = 8;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0007;
  localparam logic [31:0] PICT_RST = 32'h2020_0020;
  localparam logic [31:0] TINT_RST = 32'h0000_0000;
  localparam logic [31:0] MIX_RST  = 32'h0000_1f01;
  // mixing modes
  localparam logic [1:0] MODE_MAIN = 2'b11;
  localparam logic [1:0] MODE_MIX  = 2'b01;
  // mixing factor limits and static level
  localparam logic [6:0] K_FULL = 7'h40;
  localparam logic signed [13:0] K_HALF = 14'sh0020;
  localparam logic [5:0] STATIC_LEVEL = 6'h1f;
  localparam logic [6:0] NL_LO = 7'h10;
  localparam logic [6:0] NL_HI = 7'h30;
  // matrix coefficients, scaled by 256
  localparam logic signed [17:0] KYR = 18'sh0004d;
  localparam logic signed [17:0] KYG = 18'sh00096;
  localparam logic signed [17:0] KYB = 18'sh0001d;
  localparam logic signed [17:0] KCR = 18'sh000b3;
  localparam logic signed [17:0] KCB = 18'sh000e3;
  localparam logic signed [17:0] RND8 = 18'sh00080;
  localparam logic signed [17:0] RND5 = 18'sh00010;
  localparam logic signed [17:0] RND7 = 18'sh00040;
  // tint: sin ~ deg*143/64, cos ~ 128 - deg*deg*5/256 (scale 128)
  localparam logic signed [17:0] TINT_SIN = 18'sh0008f;
  localparam logic signed [17:0] TINT_COS = 18'sh00005;
  localparam logic signed [17:0] TINT_ONE = 18'sh00080;
  localparam logic signed [5:0]  TINT_MAX = 6'sh14;
  localparam int MAIN_LAT = 5;
endpackage

/* File: src/component_video_mixer.sv */
// component video path: matrix, picture controls, tint, softmixer and ahb-lite registers
// assumes component and blank inputs come from converters off this clock, main video on it
//
// What this block does
// - rgb input: luma = 0.299 red + 0.587 green + 0.114 blue
// - rgb input: red difference = 0.701 red - 0.587 green - 0.114 blue
// - rgb input: blue difference = -0.299 red - 0.587 green + 0.886 blue
// - component luma/colour-difference input bypasses the matrix unchanged
// - three 8-bit component samples taken every 20.25 MHz system sample
// - fast-blank arrives as a 6-bit level used for dynamic mixing
// - contrast and both saturations are gains 0 to 63/32 in 1/32 steps
// - signed brightness offset -128 to 127 added to luma
// - colour-difference pair rotated by tint between -20 and +20 degrees
// - output = (k*main + (64-k)*component)/64, k from 0 to 64
// - component and main paths are aligned so mixed samples are co-sited
// - static switch forces k to 0 or 64
// - static mixer: k = gain*(31 - offset) + 32 from registers only
// - every mixing factor is limited to 0..64
// - static modes ignore the fast-blank level
// - dynamic linear: k = gain*(level - offset) + 32, limited
// - dynamic non-linear: further mapping of the linear factor, twice as steep between 16 and 48, sharpens edges
// - mode 11 main, x0 component, 01 mix; clamp and curve pick kind, delay adds a stage
// - sync always comes from the main input, passed along with it
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module component_video_mixer (
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic                                     hreadyout,
  output logic                                     hresp,
  output logic [31:0]                              hrdata,
  input  wire logic [comp_mix_pkg::SAMPLE_W-1:0]   comp_a,
  input  wire logic [comp_mix_pkg::SAMPLE_W-1:0]   comp_b,
  input  wire logic [comp_mix_pkg::SAMPLE_W-1:0]   comp_c,
  input  wire logic [comp_mix_pkg::LEVEL_W-1:0]    blank_level,
  input  wire logic [comp_mix_pkg::SAMPLE_W-1:0]   main_y,
  input  wire logic [comp_mix_pkg::SAMPLE_W-1:0]   main_cr,
  input  wire logic [comp_mix_pkg::SAMPLE_W-1:0]   main_cb,
  input  wire logic                                main_sync,
  output logic [comp_mix_pkg::SAMPLE_W-1:0]        mix_y,
  output logic [comp_mix_pkg::SAMPLE_W-1:0]        mix_cr,
  output logic [comp_mix_pkg::SAMPLE_W-1:0]        mix_cb,
  output logic                                     mix_sync
);
  import comp_mix_pkg::*;

  function automatic logic [7:0] sat8u(input logic signed [17:0] v);
    if (v < 0) sat8u = 8'h00;
    else if (v > 18'sh000ff) sat8u = 8'hff;
    else sat8u = v[7:0];
  endfunction

  function automatic logic [7:0] sat8s(input logic signed [17:0] v);
    if (v < -18'sh00080) sat8s = 8'h80;
    else if (v > 18'sh0007f) sat8s = 8'h7f;
    else sat8s = v[7:0];
  endfunction

  function automatic logic [6:0] klimit(input logic signed [13:0] v);
    if (v < 0) klimit = 7'h00;
    else if (v > 14'sh0040) klimit = K_FULL;
    else klimit = v[6:0];
  endfunction

  function automatic logic [7:0] mix8(input logic [6:0] k, input logic [7:0] m,
                                      input logic [7:0] c);
    logic [14:0] s;
    s = 15'(k) * 15'(m) + 15'(K_FULL - k) * 15'(c) + 15'h0020;
    mix8 = s[13:6];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus: writes land in the data phase, reads take one wait state
  // so that a read right behind a write sees the new value
  logic [31:0]       addr_q;
  logic              wr_pend_q;
  logic              rd_wait_q;
  logic [31:0]       hrdata_q;
  logic              rgb_q;
  logic [1:0]        mode_q;
  logic              clamp_q;
  logic              curve_q;
  logic              dly_q;
  logic [5:0]        con_q;
  logic signed [7:0] bri_q;
  logic [5:0]        scr_q;
  logic [5:0]        scb_q;
  logic signed [5:0] tint_q;
  logic [5:0]        gain_q;
  logic [5:0]        off_q;
  logic [6:0]        k_sel;
  logic [5:0]        lvl2_q;
  logic              accept;
  logic signed [5:0] tint_w;

  assign accept    = hsel & hready & htrans[1];
  assign hreadyout = ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign tint_w    = hwdata[5:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end else begin
      if (accept) addr_q <= haddr;
      wr_pend_q <= accept & hwrite;
      rd_wait_q <= accept & ~hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      unique case (addr_q)
        OFS_CTRL: hrdata_q <= {26'h0, dly_q, curve_q, clamp_q, mode_q, rgb_q};
        OFS_PICT: hrdata_q <= {2'h0, scb_q, 2'h0, scr_q, bri_q, 2'h0, con_q};
        OFS_TINT: hrdata_q <= {{26{tint_q[5]}}, tint_q};
        OFS_MIX:  hrdata_q <= {18'h0, off_q, 2'h0, gain_q};
        OFS_STAT: hrdata_q <= {18'h0, lvl2_q, 1'b0, k_sel};
        default:  hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rgb_q   <= CTRL_RST[CTRL_RGB_BIT];
      mode_q  <= CTRL_RST[CTRL_MODE_LSB +: 2];
      clamp_q <= CTRL_RST[CTRL_CLAMP_BIT];
      curve_q <= CTRL_RST[CTRL_CURVE_BIT];
      dly_q   <= CTRL_RST[CTRL_DLY_BIT];
      con_q   <= PICT_RST[PICT_CON_LSB +: 6];
      bri_q   <= PICT_RST[PICT_BRI_LSB +: 8];
      scr_q   <= PICT_RST[PICT_SCR_LSB +: 6];
      scb_q   <= PICT_RST[PICT_SCB_LSB +: 6];
      tint_q  <= TINT_RST[5:0];
      gain_q  <= MIX_RST[MIX_GAIN_LSB +: 6];
      off_q   <= MIX_RST[MIX_OFFS_LSB +: 6];
    end else if (wr_pend_q) begin
      unique case (addr_q)
        OFS_CTRL: begin
          rgb_q   <= hwdata[CTRL_RGB_BIT];
          mode_q  <= hwdata[CTRL_MODE_LSB +: 2];
          clamp_q <= hwdata[CTRL_CLAMP_BIT];
          curve_q <= hwdata[CTRL_CURVE_BIT];
          dly_q   <= hwdata[CTRL_DLY_BIT];
        end
        OFS_PICT: begin
          con_q <= hwdata[PICT_CON_LSB +: 6];
          bri_q <= hwdata[PICT_BRI_LSB +: 8];
          scr_q <= hwdata[PICT_SCR_LSB +: 6];
          scb_q <= hwdata[PICT_SCB_LSB +: 6];
        end
        // angles beyond the rotation range are pinned to its ends
        OFS_TINT: begin
          if (tint_w > TINT_MAX) tint_q <= TINT_MAX;
          else if (tint_w < -TINT_MAX) tint_q <= -TINT_MAX;
          else tint_q <= tint_w;
        end
        OFS_MIX: begin
          gain_q <= hwdata[MIX_GAIN_LSB +: 6];
          off_q  <= hwdata[MIX_OFFS_LSB +: 6];
        end
        default: ;
      endcase
    end
  end

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite) |=> (!hreadyout ##1 hreadyout))
    else $error("read did not take exactly one wait state");

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: converter samples cross in from their own timing
  logic [7:0] a1_q, b1_q, c1_q, a2_q, b2_q, c2_q;
  logic [5:0] lvl1_q, lvl3_q, lvl4_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {a1_q, b1_q, c1_q, a2_q, b2_q, c2_q} <= 48'h0;
      {lvl1_q, lvl2_q, lvl3_q, lvl4_q} <= 24'h0;
    end else begin
      {a1_q, b1_q, c1_q} <= {comp_a, comp_b, comp_c};
      {a2_q, b2_q, c2_q} <= {a1_q, b1_q, c1_q};
      lvl1_q <= blank_level;
      lvl2_q <= lvl1_q;
      lvl3_q <= lvl2_q;
      lvl4_q <= lvl3_q;
    end
  end

  a_level_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    ##3 (lvl4_q == $past(blank_level, 4)))
    else $error("blank level pipeline delay wrong");

  ////////////////////////////////////////////////////////////////////////////
  // stage 1 matrix, stage 2 contrast/brightness/saturation, stage 3 tint
  logic signed [17:0] r_e, g_e, b_e, ysum, crsum, cbsum;
  logic signed [9:0]  y_m, cr_m, cb_m, y1_q, cr1_q, cb1_q;
  logic [7:0]         y2_q, y3_q, cr3_q, cb3_q;
  logic signed [7:0]  cr2_q, cb2_q;
  logic signed [17:0] yt, crt, cbt, cr2e, cb2e, te, sinq, cosq, crr, cbr;

  always_comb begin
    r_e   = 18'({10'h000, a2_q});
    g_e   = 18'({10'h000, b2_q});
    b_e   = 18'({10'h000, c2_q});
    ysum  = KYR * r_e + KYG * g_e + KYB * b_e + RND8;
    crsum = KCR * r_e - KYG * g_e - KYB * b_e + RND8;
    cbsum = KCB * b_e - KYR * r_e - KYG * g_e + RND8;
    if (rgb_q) begin
      y_m  = ysum[17:8];
      cr_m = crsum[17:8];
      cb_m = cbsum[17:8];
    end else begin
      y_m  = {2'b00, a2_q};
      cr_m = {2'b00, b2_q} - 10'h080;
      cb_m = {2'b00, c2_q} - 10'h080;
    end
  end

  always_comb begin
    // gains kept signed so the shift stays arithmetic for negative chroma
    yt   = ((18'(y1_q) * $signed({12'h000, con_q}) + RND5) >>> 5) + 18'(bri_q);
    crt  = (18'(cr1_q) * $signed({12'h000, scr_q}) + RND5) >>> 5;
    cbt  = (18'(cb1_q) * $signed({12'h000, scb_q}) + RND5) >>> 5;
    cr2e = 18'(cr2_q);
    cb2e = 18'(cb2_q);
    te   = 18'(tint_q);
    sinq = (te * TINT_SIN) >>> 6;
    cosq = TINT_ONE - ((te * te * TINT_COS) >>> 8);
    crr  = (cr2e * cosq - cb2e * sinq + RND7) >>> 7;
    cbr  = (cb2e * cosq + cr2e * sinq + RND7) >>> 7;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {y1_q, cr1_q, cb1_q} <= 30'h0;
      {y2_q, cr2_q, cb2_q} <= 24'h0;
      {y3_q, cr3_q, cb3_q} <= 24'h008080;
    end else begin
      {y1_q, cr1_q, cb1_q} <= {y_m, cr_m, cb_m};
      y2_q  <= sat8u(yt);
      cr2_q <= sat8s(crt);
      cb2_q <= sat8s(cbt);
      y3_q  <= y2_q;
      // back to offset binary so both mixer operands share one code
      cr3_q <= sat8s(crr) ^ 8'h80;
      cb3_q <= sat8s(cbr) ^ 8'h80;
    end
  end

  a_matrix_gray: assert property (@(posedge hclk) disable iff (!hresetn)
    (rgb_q && a2_q == b2_q && b2_q == c2_q)
      |=> (cr1_q == 10'h000 && cb1_q == 10'h000 && y1_q == {2'b00, $past(a2_q)}))
    else $error("grey rgb input did not give zero colour difference");
  a_matrix_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
    !rgb_q |=> (y1_q == {2'b00, $past(a2_q)} && cr1_q == {2'b00, $past(b2_q)} - 10'h080))
    else $error("component bypass altered samples");

  ////////////////////////////////////////////////////////////////////////////
  // main path delay: matches sync + three stages of the component path
  logic [MAIN_LAT-1:0][24:0] main_dly_q;
  logic [24:0]               main_x_q, cip_x_q, main_al, cip_al;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_dly_q <= '0;
    end else begin
      main_dly_q[0] <= {main_sync, main_cb, main_cr, main_y};
      for (int i = 1; i < MAIN_LAT; i++) main_dly_q[i] <= main_dly_q[i-1];
    end
  end

  // the extra stage keeps both operands co-sited with the slower curved factor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_x_q <= 25'h0;
      cip_x_q  <= 25'h0;
    end else begin
      main_x_q <= main_dly_q[MAIN_LAT-1];
      cip_x_q  <= {1'b0, cb3_q, cr3_q, y3_q};
    end
  end

  assign main_al = dly_q ? main_x_q : main_dly_q[MAIN_LAT-1];
  assign cip_al  = dly_q ? cip_x_q : {1'b0, cb3_q, cr3_q, y3_q};

  ////////////////////////////////////////////////////////////////////////////
  // mixing factor: linear stage aligned with stage 3, curved one a stage later
  logic              dyn;
  logic              stat;
  logic [5:0]        lvl_use;
  logic signed [13:0] kdiff, kval;
  logic [6:0]        k_lin_q, k_nl_q, k_curve;

  assign dyn  = (mode_q == MODE_MIX) && !clamp_q;
  assign stat = (mode_q == MODE_MIX) && clamp_q;

  always_comb begin
    lvl_use = stat ? STATIC_LEVEL : lvl4_q;
    kdiff   = 14'({8'h00, lvl_use}) - 14'({8'h00, off_q});
    kval    = 14'({8'h00, gain_q}) * kdiff + K_HALF;
    if (k_lin_q < NL_LO) k_curve = 7'h00;
    else if (k_lin_q > NL_HI) k_curve = K_FULL;
    else k_curve = 7'((k_lin_q - NL_LO) << 1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k_lin_q <= K_FULL;
      k_nl_q  <= K_FULL;
    end else begin
      if (mode_q == MODE_MAIN) k_lin_q <= K_FULL;
      else if (!mode_q[0]) k_lin_q <= 7'h00;
      else k_lin_q <= klimit(kval);
      k_nl_q <= dyn ? k_curve : k_lin_q;
    end
  end

  assign k_sel = curve_q ? k_nl_q : k_lin_q;

  a_force_main: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == MODE_MAIN) |=> (k_lin_q == 7'h40))
    else $error("main not forced");
  a_force_comp: assert property (@(posedge hclk) disable iff (!hresetn)
    (!mode_q[0])[*3] |-> (k_lin_q == 7'h00 && k_nl_q == 7'h00))
    else $error("component not forced");
  a_k_range: assert property (@(posedge hclk) disable iff (!hresetn)
    (k_lin_q <= 7'h40) && (k_nl_q <= 7'h40))
    else $error("mixing factor out of range");
  a_static_mid: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat && gain_q == 6'h00) |=> (k_lin_q == 7'h20))
    else $error("static factor with zero gain not 32");
  a_static_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat && !wr_pend_q)[*2] |=> $stable(k_lin_q))
    else $error("static factor moved without a register write");
  a_dyn_track: assert property (@(posedge hclk) disable iff (!hresetn)
    (dyn && gain_q == 6'h01 && off_q == 6'h00 && lvl4_q < 6'h20)
      |=> (k_lin_q == {1'b0, $past(lvl4_q)} + 7'h20))
    else $error("linear factor does not follow blank level");

  ////////////////////////////////////////////////////////////////////////////
  // softmixer, one generate lane per component
  logic [2:0][7:0] mix_q;

  for (genvar ch = 0; ch < 3; ch++) begin : g_lane
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) mix_q[ch] <= 8'h00;
      else mix_q[ch] <= mix8(k_sel, main_al[ch*8 +: 8], cip_al[ch*8 +: 8]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mix_sync <= 1'b0;
    else mix_sync <= main_al[24];
  end

  assign mix_y  = mix_q[0];
  assign mix_cr = mix_q[1];
  assign mix_cb = mix_q[2];

  a_mix_main: assert property (@(posedge hclk) disable iff (!hresetn)
    (k_sel == 7'h40) |=> (mix_y == $past(main_al[7:0]) && mix_cb == $past(main_al[23:16])))
    else $error("full factor did not pass main video");
  a_mix_comp: assert property (@(posedge hclk) disable iff (!hresetn)
    (k_sel == 7'h00) |=> (mix_cr == $past(cip_al[15:8])))
    else $error("zero factor did not pass component video");

endmodule // component_video_mixer

/* File: bench/main_video_src.sv */
// partner model: the main decoded 4:4:4 video path feeding the mixer
// assumes hclk is the shared system clock; colour levels are parameters
`timescale 1ns/1ps
module main_video_src #(
  parameter int         LINE = 32,
  parameter logic [7:0] MY   = 8'hc8,
  parameter logic [7:0] MCR  = 8'ha8,
  parameter logic [7:0] MCB  = 8'h58
) (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  output logic [comp_mix_pkg::SAMPLE_W-1:0]      main_y,
  output logic [comp_mix_pkg::SAMPLE_W-1:0]      main_cr,
  output logic [comp_mix_pkg::SAMPLE_W-1:0]      main_cb,
  output logic                                   main_sync
);
  import comp_mix_pkg::*;
  logic [7:0] cnt_q;
  assign main_y  = MY;
  assign main_cr = MCR;
  assign main_cb = MCB;
  // one sync pulse per line, so the main input carries sync in every mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q     <= 8'h00;
      main_sync <= 1'b0;
    end else begin
      cnt_q     <= (cnt_q == 8'(LINE - 1)) ? 8'h00 : cnt_q + 8'h01;
      main_sync <= (cnt_q == 8'h00);
    end
  end
endmodule // main_video_src

/* File: bench/tb_component_video_mixer.sv */
// testbench: registers over ahb-lite, component pins driven, mixed output judged
// assumes main video and sync come from the partner model on the same clock
`timescale 1ns/1ps
module tb_component_video_mixer;
  import comp_mix_pkg::*;
  localparam logic [7:0] MY  = 8'hc8;
  localparam logic [7:0] MCR = 8'ha8;
  localparam logic [7:0] MCB = 8'h58;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, main_sync, mix_sync;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  comp_a, comp_b, comp_c, main_y, main_cr, main_cb, mix_y, mix_cr, mix_cb;
  logic [5:0]  blank_level;
  int          err_total, n_checks;

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  component_video_mixer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_a(comp_a),
    .comp_b(comp_b), .comp_c(comp_c), .blank_level(blank_level), .main_y(main_y),
    .main_cr(main_cr), .main_cb(main_cb), .main_sync(main_sync), .mix_y(mix_y),
    .mix_cr(mix_cr), .mix_cb(mix_cb), .mix_sync(mix_sync)
  );

  main_video_src #(.LINE(32), .MY(MY), .MCR(MCR), .MCB(MCB)) partner (
    .hclk(hclk), .hresetn(hresetn), .main_y(main_y), .main_cr(main_cr),
    .main_cb(main_cb), .main_sync(main_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // hready is sampled at the edge, before that edge's own updates land
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic vid(input logic [23:0] v);
    comp_a <= v[23:16];
    comp_b <= v[15:8];
    comp_c <= v[7:0];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    bus(1'b0, OFS_CTRL, 32'h0, d);
    check("ctrl_rst", d, CTRL_RST);
    bus(1'b0, OFS_PICT, 32'h0, d);
    check("pict_rst", d, PICT_RST);
    bus(1'b0, OFS_TINT, 32'h0, d);
    check("tint_rst", d, TINT_RST);
    bus(1'b0, OFS_MIX, 32'h0, d);
    check("mix_rst", d, MIX_RST);
    bus(1'b1, 32'h0000_0014, 32'hffff_ffff, d);
    bus(1'b0, 32'h0000_0014, 32'h0, d);
    check("unmapped", d, 32'h0);
    check("hresp", {31'd0, hresp}, 32'h0);
    check("rst_main", {8'd0, mix_y, mix_cr, mix_cb}, {8'd0, MY, MCR, MCB});
    $display("test registers done");
  endtask

  // modes 11, 00, 10 with bypass, then the rgb matrix on a grey input
  task automatic t_force;
    logic [31:0] d;
    logic [31:0] c[4] = '{32'h6, 32'h0, 32'h4, 32'h1};
    logic [23:0] iv[4] = '{24'h643cbe, 24'h643cbe, 24'h643cbe, 24'hc8c8c8};
    logic [23:0] ex[4] = '{{MY, MCR, MCB}, 24'h643cbe, 24'h643cbe, 24'hc88080};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTRL, c[i], d);
      vid(iv[i]);
      settle(12);
      check("force_mix", {8'd0, mix_y, mix_cr, mix_cb}, {8'd0, ex[i]});
    end
    $display("test force done");
  endtask

  task automatic t_pict;
    logic [31:0] d;
    bus(1'b1, OFS_CTRL, 32'h0, d);
    bus(1'b1, OFS_PICT, 32'h3f10_0a10, d);
    vid(24'h6440a0);
    settle(12);
    check("pict_y", {24'd0, mix_y}, 32'd60);
    check("pict_crcb", {16'd0, mix_cr, mix_cb}, 32'h60bf);
    bus(1'b1, OFS_PICT, PICT_RST, d);
    vid(24'h648080);
    bus(1'b1, OFS_TINT, 32'h1e, d);
    bus(1'b0, OFS_TINT, 32'h0, d);
    check("tint_hi", d, 32'h14);
    settle(12);
    check("tint_grey", {16'd0, mix_cr, mix_cb}, 32'h8080);
    bus(1'b1, OFS_TINT, 32'h22, d);
    bus(1'b0, OFS_TINT, 32'h0, d);
    check("tint_lo", d, 32'hffff_ffec);
    bus(1'b1, OFS_TINT, TINT_RST, d);
    $display("test picture done");
  endtask

  task automatic t_mix(input logic [31:0] ctrl, input bit stat, input bit curve);
    logic [31:0] d;
    int g[5] = '{1, 1, 2, 3, 0};
    int o[5] = '{0, 20, 40, 30, 9};
    int l[5] = '{10, 5, 0, 63, 33};
    int k;
    bus(1'b1, OFS_CTRL, ctrl, d);
    vid(24'h648080);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_MIX, 32'((o[i] << 8) | g[i]), d);
      blank_level <= 6'(l[i]);
      k = g[i] * ((stat ? 31 : l[i]) - o[i]) + 32;
      k = (k < 0) ? 0 : (k > 64) ? 64 : k;
      if (curve) k = (k < 16) ? 0 : (k > 48) ? 64 : 2 * (k - 16);
      settle(12);
      bus(1'b0, OFS_STAT, 32'h0, d);
      check("k", {25'd0, d[6:0]}, 32'(k));
      check("level", {26'd0, d[13:8]}, 32'(l[i]));
      check("mix_y", {24'd0, mix_y}, 32'((k * MY + (64 - k) * 100 + 32) >> 6));
      if (stat) begin
        blank_level <= 6'(63 - l[i]);
        settle(12);
        bus(1'b0, OFS_STAT, 32'h0, d);
        check("k_static", {25'd0, d[6:0]}, 32'(k));
      end
    end
    $display("test mix %h done", ctrl);
  endtask

  // the count lands on the latency: a pre-edge sample shows the previous edge's update
  task automatic t_sync(input logic [31:0] ctrl, input int lat);
    logic [31:0] d;
    int n;
    bus(1'b1, OFS_CTRL, ctrl, d);
    n = 0;
    do begin @(posedge hclk); n++; end while (main_sync !== 1'b1 && n < 80);
    n = 0;
    do begin @(posedge hclk); n++; end while (mix_sync !== 1'b1 && n < 20);
    check("sync_delay", 32'(n), 32'(lat));
    $display("test sync %h done", ctrl);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    n_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    comp_a = 8'h00;
    comp_b = 8'h80;
    comp_c = 8'h80;
    blank_level = 6'h00;
    repeat (2) @(posedge hclk);
    check("rst_out", {hreadyout, 23'd0, mix_y}, 32'h8000_0000);
    hresetn <= 1'b1;
    settle(12);
    t_regs();
    t_force();
    t_pict();
    t_mix(32'h0000_000a, 1'b1, 1'b0);
    t_mix(32'h0000_0002, 1'b0, 1'b0);
    t_mix(32'h0000_0032, 1'b0, 1'b1);
    t_sync(32'h0000_0002, 6);
    t_sync(32'h0000_0032, 7);
    give_verdict();
  end
endmodule // tb_component_video_mixer
